// *** design/chs_pkg.sv ***
// Package for the card host strobe and handshake block.
// Assumes a single 250 MHz clock domain; host pins arrive asynchronous and are synchronised inside.
package chs_pkg;
    localparam int CLK_PERIOD_PS = 4000;
    localparam int SYNC_STAGES = 2;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 11;
    // Initialisation time before ready rises, in nanoseconds.
    localparam int INIT_TIME_NS = 2000;
    localparam int INIT_CYCLES = (INIT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W = 16;
    // Interrupt pulse width in pulse mode, in nanoseconds.
    localparam int IRQ_PULSE_NS = 40;
    localparam int IRQ_PULSE_CYCLES = (IRQ_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [1:0] MODE_MEM = 2'h0;
    localparam logic [1:0] MODE_IO = 2'h1;
    localparam logic [1:0] MODE_IDE = 2'h2;

    typedef enum logic [1:0] {
        CHS_INIT = 2'b00,
        CHS_READY = 2'b01,
        CHS_BUSY = 2'b10
    } chs_rdy_state_t;

    typedef enum logic [1:0] {
        CHS_DMA_IDLE = 2'b00,
        CHS_DMA_REQ = 2'b01,
        CHS_DMA_XFER = 2'b10
    } chs_dma_state_t;

    // Host strobe and select pins, all active low except where named.
    typedef struct packed {
        logic io_write_strobe_n;
        logic out_enable_n;
        logic attr_select_n;
        logic ide_mode_select_n;
        logic dma_ack_n;
        logic taskfile_select_n;
        logic ctrl_block_select_n;
        logic card_enable_n;
    } chs_host_pins_t;

    // Register write produced on a write strobe rising edge.
    typedef struct packed {
        logic valid;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } chs_wr_t;
endpackage : chs_pkg

// *** design/chs_sync.sv ***
// Two-flop synchroniser for a vector of host pins.
// Assumes the inputs are static or slow compared to the clock; no edge is read from stage one.
`timescale 1ns/1ps
`default_nettype none
module chs_sync
    import chs_pkg::*;
#(
    parameter int W = 8,
    parameter logic [W-1:0] RST_VAL = '1
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;
    logic [W-1:0] nxt_meta;
    logic [W-1:0] nxt_sync;

    always_comb begin
        nxt_meta = d;
        nxt_sync = meta_ff;
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            meta_ff <= RST_VAL;
            sync_ff <= RST_VAL;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign q = sync_ff;
endmodule : chs_sync
`default_nettype wire

// *** design/chs_card_host_strobe.sv ***
// Card host strobe, select, status and DMA handshake logic.
// Assumes host pins are asynchronous; the core supplies init, busy, irq and dma intent, and mode is decoded from the host pins.
// Operation
// - I/O mode latches data on write rising
// - IDE non-UDMA write behaves as I/O
// - Write line asserted in UDMA stops burst
// - Memory mode drives data on output enable
// - I/O mode output enable reads attributes only
// - Ready low while busy, high otherwise
// - Ready low until initialisation completes
// - Ready high if reset pin stuck
// - I/O mode irq low, pulse or level
// - IDE mode irq is active high
// - Ignore acknowledge when DMA disabled
// - Request held until acknowledge, reasserted if more
`timescale 1ns/1ps
`default_nettype none
module chs_card_host_strobe
    import chs_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Host pins
    input wire chs_host_pins_t host_pins,
    input wire logic [ADDR_W-1:0] host_addr,
    input wire logic [DATA_W-1:0] host_data_in,
    output logic [DATA_W-1:0] host_data_out,
    output logic host_data_oe,
    output logic ready_out,
    output logic card_irq_n,
    output logic ide_irq,
    output logic dma_req,
    output logic udma_stop,
    // Core side
    input wire logic init_done,
    input wire logic reset_pin_stuck,
    input wire logic core_busy,
    input wire logic irq_event,
    input wire logic irq_level_mode,
    input wire logic dma_enable,
    input wire logic dma_more,
    input wire logic udma_active,
    input wire logic [DATA_W-1:0] mem_rd_data,
    input wire logic [DATA_W-1:0] attr_rd_data,
    output chs_wr_t reg_wr,
    output logic [1:0] mode,
    output logic attr_access,
    output logic dma_xfer
);
    chs_host_pins_t pins_s;
    logic [ADDR_W+DATA_W-1:0] bus_s;

    chs_sync #(.W($bits(chs_host_pins_t)), .RST_VAL('1)) u_pin_sync (
        .mclk(mclk),
        .rstn(rstn),
        .d(host_pins),
        .q(pins_s)
    );

    // Address and data are stable around the strobe edge, so a plain two-stage delay keeps them aligned.
    chs_sync #(.W(ADDR_W + DATA_W), .RST_VAL('0)) u_bus_sync (
        .mclk(mclk),
        .rstn(rstn),
        .d({host_addr, host_data_in}),
        .q(bus_s)
    );

    function automatic logic rise(input logic prev, input logic cur);
        rise = !prev && cur;
    endfunction : rise

    // Strobe history and outputs.
    logic iow_prev_ff;
    logic nxt_iow_prev;
    chs_wr_t reg_wr_ff;
    chs_wr_t nxt_reg_wr;
    logic stop_ff;
    logic nxt_stop;
    logic [DATA_W-1:0] dout_ff;
    logic [DATA_W-1:0] nxt_dout;
    logic doe_ff;
    logic nxt_doe;
    logic [1:0] mode_ff;
    logic [1:0] nxt_mode;

    always_comb begin
        nxt_mode = MODE_MEM;
        if (!pins_s.ide_mode_select_n) begin
            nxt_mode = MODE_IDE;
        end else if (!pins_s.attr_select_n && pins_s.out_enable_n && !pins_s.card_enable_n &&
                     !pins_s.io_write_strobe_n) begin
            nxt_mode = MODE_IO;
        end else if (mode_ff == MODE_IO) begin
            nxt_mode = MODE_IO;
        end
        if (pins_s.ide_mode_select_n && mode_ff == MODE_IDE) begin
            nxt_mode = MODE_MEM;
        end
    end

    always_comb begin
        nxt_iow_prev = pins_s.io_write_strobe_n;
        nxt_reg_wr = '0;
        nxt_stop = 1'b0;
        if (mode_ff == MODE_IDE && udma_active) begin
            // The write line is the stop signal while a burst runs; its assertion ends the burst.
            nxt_stop = !pins_s.io_write_strobe_n;
        end else if (mode_ff != MODE_MEM && rise(iow_prev_ff, pins_s.io_write_strobe_n)) begin
            nxt_reg_wr.valid = 1'b1;
            nxt_reg_wr.addr = bus_s[ADDR_W+DATA_W-1:DATA_W];
            nxt_reg_wr.data = bus_s[DATA_W-1:0];
        end
    end

    always_comb begin
        nxt_doe = 1'b0;
        nxt_dout = dout_ff;
        if (!pins_s.out_enable_n && !pins_s.card_enable_n) begin
            if (mode_ff == MODE_MEM) begin
                nxt_doe = 1'b1;
                nxt_dout = pins_s.attr_select_n ? mem_rd_data : attr_rd_data;
            end else if (mode_ff == MODE_IO && !pins_s.attr_select_n) begin
                nxt_doe = 1'b1;
                nxt_dout = attr_rd_data;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            iow_prev_ff <= 1'b1;
            reg_wr_ff <= '0;
            stop_ff <= 1'b0;
            dout_ff <= '0;
            doe_ff <= 1'b0;
            mode_ff <= MODE_MEM;
        end else begin
            iow_prev_ff <= nxt_iow_prev;
            reg_wr_ff <= nxt_reg_wr;
            stop_ff <= nxt_stop;
            dout_ff <= nxt_dout;
            doe_ff <= nxt_doe;
            mode_ff <= nxt_mode;
        end
    end

    // Ready state machine.
    chs_rdy_state_t rdy_ff;
    chs_rdy_state_t nxt_rdy;
    logic [CNT_W-1:0] init_cnt_ff;
    logic [CNT_W-1:0] nxt_init_cnt;

    always_comb begin
        nxt_rdy = rdy_ff;
        nxt_init_cnt = init_cnt_ff;
        case (rdy_ff)
            CHS_INIT: begin
                if (init_cnt_ff != CNT_W'(INIT_CYCLES)) begin
                    nxt_init_cnt = init_cnt_ff + CNT_W'(1);
                end
                // The timer is a floor; the core's own completion flag finally releases ready.
                if (init_done && init_cnt_ff == CNT_W'(INIT_CYCLES)) begin
                    nxt_rdy = CHS_READY;
                end
            end
            CHS_READY: begin
                if (core_busy) begin
                    nxt_rdy = CHS_BUSY;
                end
            end
            CHS_BUSY: begin
                if (!core_busy) begin
                    nxt_rdy = CHS_READY;
                end
            end
            default: begin
                nxt_rdy = CHS_INIT;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rdy_ff <= CHS_INIT;
            init_cnt_ff <= '0;
        end else begin
            rdy_ff <= nxt_rdy;
            init_cnt_ff <= nxt_init_cnt;
        end
    end

    // Interrupt generation.
    logic irq_act_ff;
    logic nxt_irq_act;
    logic [7:0] irq_cnt_ff;
    logic [7:0] nxt_irq_cnt;
    logic irq_ev_prev_ff;
    logic nxt_irq_ev_prev;

    // A pulse fires once per new event that rises while no pulse runs; a held event must not retrigger a train of pulses.
    always_comb begin
        nxt_irq_ev_prev = irq_event;
        nxt_irq_act = 1'b0;
        nxt_irq_cnt = '0;
        if (irq_level_mode || mode_ff == MODE_IDE) begin
            nxt_irq_act = irq_event;
        end else if (rise(irq_ev_prev_ff, irq_event) && irq_cnt_ff == 8'h00) begin
            nxt_irq_act = 1'b1;
            nxt_irq_cnt = 8'(IRQ_PULSE_CYCLES);
        end else if (irq_cnt_ff != 8'h00) begin
            nxt_irq_cnt = irq_cnt_ff - 8'h01;
            nxt_irq_act = (irq_cnt_ff != 8'h01);
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            irq_act_ff <= 1'b0;
            irq_cnt_ff <= '0;
            irq_ev_prev_ff <= 1'b0;
        end else begin
            irq_act_ff <= nxt_irq_act;
            irq_cnt_ff <= nxt_irq_cnt;
            irq_ev_prev_ff <= nxt_irq_ev_prev;
        end
    end

    // DMA handshake.
    chs_dma_state_t dma_ff;
    chs_dma_state_t nxt_dma;
    logic ack_ok;

    // Acknowledge counts only with DMA on and both register selects quiet.
    assign ack_ok = dma_enable && !pins_s.dma_ack_n && pins_s.taskfile_select_n &&
                    pins_s.ctrl_block_select_n;

    always_comb begin
        nxt_dma = dma_ff;
        case (dma_ff)
            CHS_DMA_IDLE: begin
                if (dma_enable && dma_more && mode_ff == MODE_IDE) begin
                    nxt_dma = CHS_DMA_REQ;
                end
            end
            CHS_DMA_REQ: begin
                if (!dma_enable) begin
                    nxt_dma = CHS_DMA_IDLE;
                end else if (ack_ok) begin
                    nxt_dma = CHS_DMA_XFER;
                end
            end
            CHS_DMA_XFER: begin
                if (!ack_ok) begin
                    nxt_dma = (dma_enable && dma_more) ? CHS_DMA_REQ : CHS_DMA_IDLE;
                end
            end
            default: begin
                nxt_dma = CHS_DMA_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            dma_ff <= CHS_DMA_IDLE;
        end else begin
            dma_ff <= nxt_dma;
        end
    end

    assign host_data_out = dout_ff;
    assign host_data_oe = doe_ff;
    assign ready_out = reset_pin_stuck || rdy_ff == CHS_READY;
    assign card_irq_n = !(irq_act_ff && mode_ff == MODE_IO);
    assign ide_irq = irq_act_ff && mode_ff == MODE_IDE;
    assign dma_req = dma_ff == CHS_DMA_REQ;
    assign dma_xfer = dma_ff == CHS_DMA_XFER;
    assign udma_stop = stop_ff;
    assign reg_wr = reg_wr_ff;
    assign mode = mode_ff;
    assign attr_access = !pins_s.attr_select_n;
endmodule : chs_card_host_strobe
`default_nettype wire

// *** sim/chs_checker_assertions.sv ***
// Checker for the card host strobe block, bound to its top module.
// Assumes one mclk domain; host pins are seen as the card samples them.
`timescale 1ns/1ps
`default_nettype none
module chs_checker
    import chs_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Observed ports
    input wire chs_host_pins_t host_pins,
    input wire logic host_data_oe,
    input wire logic ready_out,
    input wire logic card_irq_n,
    input wire logic ide_irq,
    input wire logic dma_req,
    input wire logic udma_stop,
    input wire logic init_done,
    input wire logic reset_pin_stuck,
    input wire logic core_busy,
    input wire logic irq_event,
    input wire logic irq_level_mode,
    input wire logic dma_enable,
    input wire logic udma_active,
    input wire chs_wr_t reg_wr,
    input wire logic [1:0] mode,
    input wire logic dma_xfer
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    init_ready_low_a: assert property (!init_done && !reset_pin_stuck |-> !ready_out)
        else $error("ready high before initialisation");
    stuck_ready_a: assert property (reset_pin_stuck |-> ready_out)
        else $error("ready low with reset pin stuck");
    busy_ready_a: assert property ((mode == MODE_MEM && core_busy && !reset_pin_stuck)[*4] |-> !ready_out)
        else $error("ready high while busy");
    io_write_a: assert property (mode == MODE_IO && $rose(host_pins.io_write_strobe_n) |-> ##[2:4] reg_wr.valid)
        else $error("write strobe rise not latched");
    udma_stop_a: assert property (udma_active && mode == MODE_IDE && $fell(host_pins.io_write_strobe_n)
        |-> ##[2:4] udma_stop)
        else $error("stop not seen in burst");
    mem_read_a: assert property ((mode == MODE_MEM && !host_pins.out_enable_n && !host_pins.card_enable_n)[*4]
        |-> host_data_oe)
        else $error("memory read not driven");
    io_oe_a: assert property ((mode == MODE_IO && host_pins.attr_select_n)[*5] |-> !host_data_oe)
        else $error("common read driven in io mode");
    level_irq_a: assert property ((mode == MODE_IO && irq_level_mode && irq_event)[*4] |-> !card_irq_n)
        else $error("level interrupt not held low");
    ide_irq_a: assert property (mode != MODE_IDE |-> !ide_irq)
        else $error("ide interrupt outside ide mode");
    dma_off_a: assert property ((!dma_enable)[*5] |-> !dma_xfer)
        else $error("transfer while dma disabled");
    ack_drop_a: assert property ($fell(host_pins.dma_ack_n) && dma_req && dma_enable && host_pins.taskfile_select_n
        && host_pins.ctrl_block_select_n |-> ##[2:4] !dma_req)
        else $error("request kept after acknowledge");
    cover property (reg_wr.valid);
    cover property (udma_stop);
    cover property ($fell(dma_req));
endmodule : chs_checker
bind chs_card_host_strobe chs_checker checker_i (.mclk, .rstn, .host_pins, .host_data_oe, .ready_out, .card_irq_n,
    .ide_irq, .dma_req, .udma_stop, .init_done, .reset_pin_stuck, .core_busy, .irq_event, .irq_level_mode,
    .dma_enable, .udma_active, .reg_wr, .mode, .dma_xfer);
`default_nettype wire

// *** sim/chs_host_model.sv ***
// Host controller model driving the card's strobe and select pins.
// Assumes each call comes just after a rising mclk edge; all changes are non-blocking.
`timescale 1ns/1ps
`default_nettype none
module chs_host_model
    import chs_pkg::*;
(
    // Clock
    input wire logic mclk,
    // Host pins
    output var chs_host_pins_t host_pins,
    output var logic [ADDR_W-1:0] host_addr,
    output var logic [DATA_W-1:0] host_data_in
);
    initial host_pins = '1;
    initial host_addr = '0;
    initial host_data_in = '0;
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic reg_n);
        host_addr <= a;
        host_data_in <= d;
        host_pins.attr_select_n <= reg_n;
        host_pins.card_enable_n <= 1'b0;
        host_pins.taskfile_select_n <= 1'b0;
        host_pins.io_write_strobe_n <= 1'b0;
        repeat (4) @(posedge mclk);
        host_pins.io_write_strobe_n <= 1'b1;
        repeat (4) @(posedge mclk);
        // A released bus shows the inverse, so stale data cannot pass for held data.
        host_data_in <= ~d;
        host_pins.card_enable_n <= 1'b1;
        host_pins.taskfile_select_n <= 1'b1;
        host_pins.attr_select_n <= 1'b1;
        // Idle long enough that the next call keeps every strobe phase at least three cycles.
        repeat (3) @(posedge mclk);
    endtask : wr
    task automatic rd(input logic oe_n, input logic reg_n);
        host_pins.attr_select_n <= reg_n;
        host_pins.card_enable_n <= oe_n;
        host_pins.out_enable_n <= oe_n;
    endtask : rd
    task automatic strobe(input logic v);
        host_pins.io_write_strobe_n <= v;
    endtask : strobe
    task automatic ide(input logic v);
        host_pins.ide_mode_select_n <= v;
    endtask : ide
    task automatic ack(input logic v, input logic sel_n);
        host_pins.taskfile_select_n <= sel_n;
        host_pins.ctrl_block_select_n <= sel_n;
        host_pins.dma_ack_n <= v;
    endtask : ack
endmodule : chs_host_model
`default_nettype wire

// *** sim/card_host_strobe_handshake_tb.sv ***
// Testbench for the card host strobe and handshake block.
// Assumes the host model owns every host pin; core inputs are driven here.
`timescale 1ns/1ps
`default_nettype none
module card_host_strobe_handshake_tb;
    import chs_pkg::*;
    logic mclk = 1'b0;
    logic rstn;
    logic init_done;
    logic reset_pin_stuck;
    logic core_busy;
    logic irq_event;
    logic irq_level_mode;
    logic dma_enable;
    logic dma_more;
    logic udma_active;
    logic [DATA_W-1:0] mem_rd_data;
    logic [DATA_W-1:0] attr_rd_data;
    chs_host_pins_t host_pins;
    logic [ADDR_W-1:0] host_addr;
    logic [DATA_W-1:0] host_data_in, host_data_out;
    logic host_data_oe, ready_out, card_irq_n, ide_irq, dma_req, udma_stop, attr_access, dma_xfer;
    logic [1:0] mode;
    chs_wr_t reg_wr, last_wr;
    int errors = 0;
    int tests_run = 0;
    int wr_cnt = 0;
    int low_cnt = 0;
    int cycles = 0;
    chs_card_host_strobe dut (.mclk, .rstn, .host_pins, .host_addr, .host_data_in, .host_data_out, .host_data_oe,
        .ready_out, .card_irq_n, .ide_irq, .dma_req, .udma_stop, .init_done, .reset_pin_stuck, .core_busy,
        .irq_event, .irq_level_mode, .dma_enable, .dma_more, .udma_active, .mem_rd_data, .attr_rd_data,
        .reg_wr, .mode, .attr_access, .dma_xfer);
    chs_host_model host (.mclk, .host_pins, .host_addr, .host_data_in);
    initial begin
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (reg_wr.valid === 1'b1) begin
            last_wr <= reg_wr;
            wr_cnt <= wr_cnt + 1;
        end
        if (card_irq_n === 1'b0) low_cnt <= low_cnt + 1;
        // The whole run needs about 740 cycles; anything far past that is a hang.
        if (cycles == 4000) begin
            errors++;
            results();
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : cyc
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic results();
        if (errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results
    task automatic t_ready();
        cyc(300);
        chk(ready_out, 1'b0);
        init_done <= 1'b1;
        cyc(150);
        chk(ready_out, 1'b0);
        cyc(60);
        chk(ready_out, 1'b1);
        core_busy <= 1'b1;
        cyc(5);
        chk(ready_out, 1'b0);
        reset_pin_stuck <= 1'b1;
        cyc(2);
        chk(ready_out, 1'b1);
        reset_pin_stuck <= 1'b0;
        core_busy <= 1'b0;
        cyc(5);
        chk(ready_out, 1'b1);
    endtask : t_ready
    task automatic t_mem();
        host.rd(1'b0, 1'b1);
        cyc(5);
        chk(host_data_oe, 1'b1);
        chk(host_data_out, mem_rd_data);
        host.rd(1'b0, 1'b0);
        mem_rd_data <= 16'h6996;
        cyc(5);
        chk(host_data_out, attr_rd_data);
        chk(attr_access, 1'b1);
        host.rd(1'b0, 1'b1);
        cyc(5);
        chk(host_data_out, 16'h6996);
        host.rd(1'b1, 1'b1);
        cyc(5);
        chk(host_data_oe, 1'b0);
        chk(attr_access, 1'b0);
        host.wr(11'h155, 16'h1234, 1'b1);
        chk(16'(wr_cnt), 16'h0);
    endtask : t_mem
    task automatic t_io();
        int n;
        host.wr(11'h2A5, 16'hC0DE, 1'b0);
        chk(mode, MODE_IO);
        n = wr_cnt;
        host.wr(11'h0FF, 16'hBEEF, 1'b0);
        host.wr(11'h700, 16'h8001, 1'b0);
        chk(16'(wr_cnt - n), 16'h2);
        chk(16'(last_wr.addr), 16'h0700);
        chk(last_wr.data, 16'h8001);
        host.rd(1'b0, 1'b1);
        cyc(6);
        chk(host_data_oe, 1'b0);
        host.rd(1'b0, 1'b0);
        attr_rd_data <= 16'hC3A5;
        cyc(6);
        chk(host_data_oe, 1'b1);
        chk(host_data_out, 16'hC3A5);
        host.rd(1'b1, 1'b1);
    endtask : t_io
    task automatic t_irq();
        int n;
        irq_level_mode <= 1'b1;
        irq_event <= 1'b1;
        cyc(20);
        chk(card_irq_n, 1'b0);
        chk(ide_irq, 1'b0);
        irq_event <= 1'b0;
        irq_level_mode <= 1'b0;
        cyc(10);
        n = low_cnt;
        irq_event <= 1'b1;
        cyc(30);
        irq_event <= 1'b0;
        chk(16'(low_cnt - n), 16'(IRQ_PULSE_CYCLES));
    endtask : t_irq
    task automatic t_ide();
        int n;
        host.ide(1'b0);
        irq_event <= 1'b1;
        cyc(6);
        chk(mode, MODE_IDE);
        chk(ide_irq, 1'b1);
        chk(card_irq_n, 1'b1);
        irq_event <= 1'b0;
        n = wr_cnt;
        host.wr(11'h3C7, 16'h4321, 1'b1);
        chk(16'(wr_cnt - n), 16'h1);
        chk(last_wr.data, 16'h4321);
        udma_active <= 1'b1;
        cyc(3);
        n = wr_cnt;
        host.strobe(1'b0);
        cyc(5);
        chk(udma_stop, 1'b1);
        host.strobe(1'b1);
        cyc(6);
        chk(udma_stop, 1'b0);
        chk(16'(wr_cnt - n), 16'h0);
        udma_active <= 1'b0;
    endtask : t_ide
    task automatic t_dma();
        host.ack(1'b0, 1'b1);
        cyc(6);
        chk(dma_xfer, 1'b0);
        host.ack(1'b1, 1'b1);
        cyc(5);
        dma_enable <= 1'b1;
        dma_more <= 1'b1;
        cyc(3);
        chk(dma_req, 1'b1);
        // An acknowledge with a register select low is refused.
        host.ack(1'b0, 1'b0);
        cyc(6);
        chk(dma_req, 1'b1);
        chk(dma_xfer, 1'b0);
        host.ack(1'b1, 1'b1);
        cyc(4);
        host.ack(1'b0, 1'b1);
        cyc(6);
        chk(dma_req, 1'b0);
        chk(dma_xfer, 1'b1);
        host.ack(1'b1, 1'b1);
        cyc(6);
        chk(dma_req, 1'b1);
        dma_more <= 1'b0;
        host.ack(1'b0, 1'b1);
        cyc(6);
        host.ack(1'b1, 1'b1);
        cyc(6);
        chk(dma_req, 1'b0);
        dma_enable <= 1'b0;
    endtask : t_dma
    initial begin
        rstn <= 1'b0;
        init_done <= 1'b0;
        reset_pin_stuck <= 1'b0;
        core_busy <= 1'b0;
        irq_event <= 1'b0;
        irq_level_mode <= 1'b0;
        dma_enable <= 1'b0;
        dma_more <= 1'b0;
        udma_active <= 1'b0;
        mem_rd_data <= 16'hA5C3;
        attr_rd_data <= 16'h5A3C;
        cyc(4);
        rstn <= 1'b1;
        t_ready();
        t_mem();
        t_io();
        t_irq();
        t_ide();
        t_dma();
        results();
    end
endmodule : card_host_strobe_handshake_tb
`default_nettype wire
